// ===== mas_pkg.sv
// Purpose: shared constants, types and helpers for the metering signal path
// Assumes: one clock (the master input clock), synchronous active-low reset
// Notes on behaviour
// [R1] modulator bits are taken every fourth master input clock edge
// [R2] each one-bit stream is averaged by a low-pass decimator into 24 bits
// [R3] every channel delivers a 24-bit twos-complement sample per 512 clocks
// [R4] current channels reach about +/-6,500,000 LSB at full scale
// [R5] voltage channel reaches about +/-6,500,000 LSB at full scale
// [R6] current A and current B each have their own gain register
// [R7] gain registers answer at their address and 0x100 above it
// [R8] all three paths hold a dc-blocking filter, enabled after reset
// [R9] clearing configuration bit 2 bypasses all three dc-blocking filters
// [R10] integrators are off after reset; bit 0 enables current A integrator
// [R11] bit 1 enables the current B integrator independently
// [R12] software enables an integrator only for di/dt sensors
// [R13] primary voltage gain scales the voltage channel samples
// [R14] software writes secondary voltage gain equal to the primary one
// [R15] internal reference after reset; reference bit 0 selects external
// [R16] amp codes 0-5 for current A, 0-4 elsewhere, all reset to gain 1
// [R17] all three channels present samples on one common strobe
// [R18] dc block, integrator, gain run in order, done before next strobe
package mas_pkg;

   localparam int SMP_W      = 24;
   localparam int GAIN_W     = 24;
   localparam int ACC_W      = 48;
   localparam int ADDR_W     = 12;
   localparam int NCH        = 3;
   localparam int MOD_DIV    = 4;
   localparam int DECIM      = 128;
   localparam int SMP_PERIOD = MOD_DIV * DECIM;
   localparam int CIC_W      = 24;
   localparam int FS_SHIFT   = 8;
   localparam int GAIN_FRAC  = 23;
   localparam int HPF_K      = 9;
   localparam int INT_LEAK   = 12;
   localparam int INT_SHIFT  = 6;

   localparam logic [9:0]        FS_MULT   = 10'h319;
   localparam logic [ADDR_W-1:0] ADDR_AMPV = 12'h0007;
   localparam logic [ADDR_W-1:0] ADDR_AMPA = 12'h0008;
   localparam logic [ADDR_W-1:0] ADDR_AMPB = 12'h0009;
   localparam logic [ADDR_W-1:0] ADDR_CFG  = 12'h0102;
   localparam logic [ADDR_W-1:0] ADDR_GIA  = 12'h0280;
   localparam logic [ADDR_W-1:0] ADDR_GVP  = 12'h0281;
   localparam logic [ADDR_W-1:0] ADDR_GIB  = 12'h028c;
   localparam logic [ADDR_W-1:0] ADDR_GVS  = 12'h028d;
   localparam logic [ADDR_W-1:0] ADDR_REF  = 12'h0800;
   localparam logic [ADDR_W-1:0] GAIN_ALIAS = 12'h0100;

   localparam int CFG_INT_A = 0;
   localparam int CFG_INT_B = 1;
   localparam int CFG_HPF   = 2;
   localparam int REF_EXT   = 0;
   localparam logic [15:0]       CFG_RST  = 16'h0004;
   localparam logic [7:0]        REF_RST  = 8'h00;
   localparam logic [GAIN_W-1:0] GAIN_RST = 24'h00_0000;
   localparam logic [2:0]        AMP_RST  = 3'h0;
   localparam logic [2:0]        AMP_MAXA = 3'h5;
   localparam logic [2:0]        AMP_MAX  = 3'h4;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [23:0]       wdata;
   } mas_req_s;

   typedef struct packed {
      logic [SMP_W-1:0] ia;
      logic [SMP_W-1:0] ib;
      logic [SMP_W-1:0] v;
   } mas_smp_s;

   // clamp a wide signed value into the sample range
   function automatic logic [SMP_W-1:0] sat_smp(input logic signed [ACC_W-1:0] v);
      logic signed [ACC_W-1:0] hi;
      logic signed [ACC_W-1:0] lo;
      hi = ACC_W'(signed'({1'b0, {(SMP_W-1){1'b1}}}));
      lo = ACC_W'(signed'({1'b1, {(SMP_W-1){1'b0}}}));
      if (v > hi) return hi[SMP_W-1:0];
      if (v < lo) return lo[SMP_W-1:0];
      return v[SMP_W-1:0];
   endfunction

endpackage

// ===== mas_decim.sv
// Purpose: third-order integrator-comb decimator for one modulator stream
// Assumes: dec_tick only ever coincides with tick
// Notes: output gain 2^21 is rescaled so full scale lands near 6.5M LSB
`timescale 1ns/10ps
module mas_decim
   import mas_pkg::*;
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // timing strobes
   input  wire logic             tick,
   input  wire logic             dec_tick,
   // modulator bit (already synchronised)
   input  wire logic             mod_bit,
   // decimated sample
   output logic                  out_vld,
   output logic [SMP_W-1:0]      out_smp
);
   localparam logic signed [CIC_W-1:0] CIC_P1 = CIC_W'(1);

   logic signed [CIC_W-1:0] x;
   logic signed [CIC_W-1:0] i1_q, i2_q, i3_q;
   logic signed [CIC_W-1:0] d1_q, d2_q, d3_q;
   logic signed [CIC_W-1:0] c1, c2, c3;
   logic signed [ACC_W-1:0] scaled;

   // [R2] bit to +/-1
   assign x      = mod_bit ? CIC_P1 : -CIC_P1;
   assign c1     = i3_q - d1_q;
   assign c2     = c1 - d2_q;
   assign c3     = c2 - d3_q;
   // [R4] [R5] full-scale rescale
   assign scaled = (ACC_W'(c3) * ACC_W'(signed'({1'b0, FS_MULT})))
                   >>> FS_SHIFT;

   // [R2] integrate, then comb
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         i1_q <= '0;
         i2_q <= '0;
         i3_q <= '0;
      end else if (tick) begin
         i1_q <= i1_q + x;
         i2_q <= i2_q + i1_q;
         i3_q <= i3_q + i2_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         d1_q    <= '0;
         d2_q    <= '0;
         d3_q    <= '0;
         out_smp <= '0;
         out_vld <= 1'b0;
      end else begin
         out_vld <= dec_tick;
         if (dec_tick) begin
            d1_q    <= i3_q;
            d2_q    <= c1;
            d3_q    <= c2;
            out_smp <= sat_smp(scaled);
         end
      end
   end

endmodule // mas_decim

// ===== mas_post.sv
// Purpose: per-channel dc block, optional integrator and digital gain
// Assumes: in_vld pulses at most once per sample period
// Notes: all three stages settle in the cycle after in_vld
`timescale 1ns/10ps
module mas_post
   import mas_pkg::*;
#(
   parameter bit HAS_INT = 1'b1
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // sample in
   input  wire logic              in_vld,
   input  wire logic [SMP_W-1:0]  in_smp,
   // controls
   input  wire logic              hpf_en,
   input  wire logic              int_en,
   input  wire logic [GAIN_W-1:0] gain,
   // sample out
   output logic                   out_vld,
   output logic [SMP_W-1:0]       out_smp
);
   localparam int DC_W = SMP_W + HPF_K;
   localparam int IN_W = SMP_W + INT_LEAK + 4;

   logic signed [DC_W-1:0]  dc_q, dc_d;
   logic signed [IN_W-1:0]  int_q, int_d;
   logic signed [ACC_W-1:0] x, dc, hp, it, st, prod, gx;
   logic [SMP_W-1:0]        hp_s, st_s;
   wire                     int_on = HAS_INT && int_en;

   assign x    = ACC_W'(signed'(in_smp));
   assign dc   = ACC_W'(dc_q >>> HPF_K);
   assign dc_d = dc_q + DC_W'(x) - (dc_q >>> HPF_K);
   // [R9] dc block or bypass
   assign hp_s = hpf_en ? sat_smp(x - dc) : in_smp;
   assign hp   = ACC_W'(signed'(hp_s));
   // leaky so a residual offset cannot run the integrator away
   assign int_d = int_q + IN_W'(hp) - (int_q >>> INT_LEAK);
   assign it    = ACC_W'(int_d >>> INT_SHIFT);
   // [R10] integrator insertion
   assign st_s = int_on ? sat_smp(it) : hp_s;
   assign st   = ACC_W'(signed'(st_s));
   // [R6] gain is 1 + g/2^23
   assign prod = st * ACC_W'(signed'(gain));
   assign gx   = st + (prod >>> GAIN_FRAC);

   // [R18] stages in fixed order
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         dc_q    <= '0;
         int_q   <= '0;
         out_smp <= '0;
         out_vld <= 1'b0;
      end else begin
         out_vld <= in_vld;
         if (in_vld) begin
            dc_q    <= dc_d;
            int_q   <= int_on ? int_d : '0;
            out_smp <= sat_smp(gx);
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_bypass;
      in_vld && !hpf_en && !int_on && gain == GAIN_RST
      |=> out_smp == $past(in_smp);
   endproperty
   a_bypass: assert property (p_bypass) // [R9]
      else $error("bypassed path altered the sample");

   property p_int_off;
      in_vld && !int_on |=> int_q == '0;
   endproperty
   a_int_off: assert property (p_int_off) // [R10]
      else $error("integrator state kept while disabled");

   c_int_on: cover property (in_vld && int_on && hpf_en);

endmodule // mas_post

// ===== mas_signal_path.sv
// Purpose: three-channel decimation and sample conditioning with registers
// Assumes: modulator bits arrive asynchronously; register port is same-clock
// Notes: register reads answer one cycle after the request
`timescale 1ns/10ps
module mas_signal_path
   import mas_pkg::*;
(
   // master input clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // modulator streams: 0 current a, 1 current b, 2 voltage
   input  wire logic [NCH-1:0]   mod_bit_pin,
   output logic                  mod_strobe,
   // register access
   input  wire mas_req_s         reg_req,
   output logic [23:0]           reg_rdata,
   output logic                  reg_rvld,
   // analog controls
   output logic [2:0]            current_amp_setting_a,
   output logic [2:0]            current_amp_setting_b,
   output logic [2:0]            voltage_amp_setting,
   output logic                  reference_external,
   // samples
   output logic                  smp_vld,
   output mas_smp_s              smp
);
   // register state
   logic [15:0]       cfg_q;
   logic [GAIN_W-1:0] gia_q, gvp_q, gib_q, gvs_q;
   logic [7:0]        ref_q;
   logic [2:0]        amp_a_q, amp_b_q, amp_v_q;
   logic [23:0]       rdata_d;

   // timing
   logic [1:0]        div_q;
   logic [6:0]        dec_q;
   logic [NCH-1:0]    mod_s1_q, mod_s2_q;
   wire               tick;
   wire               dec_tick;

   // per-channel wiring
   logic [NCH-1:0]    dec_vld, post_vld, int_en;
   logic [SMP_W-1:0]  dec_smp  [NCH];
   logic [SMP_W-1:0]  post_smp [NCH];
   logic [GAIN_W-1:0] ch_gain  [NCH];

   // register decode
   wire wr = reg_req.wr;
   wire [ADDR_W-1:0] ad = reg_req.addr;
   wire [23:0] wd = reg_req.wdata;

   function automatic logic alias_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base);
      return (a == base) || (a == base + GAIN_ALIAS);
   endfunction

   // [R7] both pages
   wire hit_gia = alias_hit(ad, ADDR_GIA);
   wire hit_gvp = alias_hit(ad, ADDR_GVP);
   wire hit_gib = alias_hit(ad, ADDR_GIB);
   wire hit_gvs = alias_hit(ad, ADDR_GVS);
   wire hit_cfg = (ad == ADDR_CFG);
   wire hit_ref = (ad == ADDR_REF);
   wire hit_ama = (ad == ADDR_AMPA);
   wire hit_amb = (ad == ADDR_AMPB);
   wire hit_amv = (ad == ADDR_AMPV);
   // [R16] codes beyond the table are ignored
   wire ok_ama  = wd[2:0] <= AMP_MAXA;
   wire ok_amb  = wd[2:0] <= AMP_MAX;

   assign rdata_d = hit_gia ? gia_q :
                    hit_gvp ? gvp_q :
                    hit_gib ? gib_q :
                    hit_gvs ? gvs_q :
                    hit_cfg ? {8'h00, cfg_q} :
                    hit_ref ? {16'h0000, ref_q} :
                    hit_ama ? {21'h00_0000, amp_a_q} :
                    hit_amb ? {21'h00_0000, amp_b_q} :
                    hit_amv ? {21'h00_0000, amp_v_q} :
                    24'h00_0000;

   // [R6] gain writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         gia_q <= GAIN_RST;
         gvp_q <= GAIN_RST;
         gib_q <= GAIN_RST;
         gvs_q <= GAIN_RST;
      end else if (wr) begin
         if (hit_gia) gia_q <= wd;
         if (hit_gvp) gvp_q <= wd;
         if (hit_gib) gib_q <= wd;
         if (hit_gvs) gvs_q <= wd;
      end
   end

   // [R8] [R10] [R15] control reset values
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg_q <= CFG_RST;
         ref_q <= REF_RST;
      end else if (wr) begin
         if (hit_cfg) cfg_q <= wd[15:0];
         if (hit_ref) ref_q <= wd[7:0];
      end
   end

   // [R16] amplifier codes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         amp_a_q <= AMP_RST;
         amp_b_q <= AMP_RST;
         amp_v_q <= AMP_RST;
      end else if (wr) begin
         if (hit_ama && ok_ama) amp_a_q <= wd[2:0];
         if (hit_amb && ok_amb) amp_b_q <= wd[2:0];
         if (hit_amv && ok_amb) amp_v_q <= wd[2:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= '0;
         reg_rvld  <= 1'b0;
      end else begin
         reg_rvld <= reg_req.rd;
         if (reg_req.rd) reg_rdata <= rdata_d;
      end
   end

   assign current_amp_setting_a = amp_a_q;
   assign current_amp_setting_b = amp_b_q;
   assign voltage_amp_setting   = amp_v_q;
   // [R15] reference select
   assign reference_external    = ref_q[REF_EXT];

   // [R1] divide by four
   assign tick       = (div_q == 2'(MOD_DIV - 1));
   assign dec_tick   = tick && (dec_q == 7'(DECIM - 1));
   assign mod_strobe = tick;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         div_q <= '0;
         dec_q <= '0;
      end else begin
         div_q <= div_q + 2'(1);
         if (tick) dec_q <= dec_q + 7'(1);
      end
   end

   // pins are asynchronous to the master clock
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mod_s1_q <= '0;
         mod_s2_q <= '0;
      end else begin
         mod_s1_q <= mod_bit_pin;
         mod_s2_q <= mod_s1_q;
      end
   end

   // [R13] voltage uses the primary gain
   assign ch_gain[0] = gia_q;
   assign ch_gain[1] = gib_q;
   assign ch_gain[2] = gvp_q;
   // [R11] independent integrator enables
   assign int_en = {1'b0, cfg_q[CFG_INT_B], cfg_q[CFG_INT_A]};

   // [R17] one shared decimation strobe for every channel
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      mas_decim u_decim (
         .clock    (clock),
         .rst_n    (rst_n),
         .tick     (tick),
         .dec_tick (dec_tick),
         .mod_bit  (mod_s2_q[c]),
         .out_vld  (dec_vld[c]),
         .out_smp  (dec_smp[c])
      );
      mas_post #(
         .HAS_INT (c < 2)
      ) u_post (
         .clock   (clock),
         .rst_n   (rst_n),
         .in_vld  (dec_vld[c]),
         .in_smp  (dec_smp[c]),
         .hpf_en  (cfg_q[CFG_HPF]),
         .int_en  (int_en[c]),
         .gain    (ch_gain[c]),
         .out_vld (post_vld[c]),
         .out_smp (post_smp[c])
      );
   end

   // [R3] common sample strobe
   assign smp_vld = post_vld[0];
   assign smp     = '{ia: post_smp[0], ib: post_smp[1], v: post_smp[2]};

   // helper: cycles since the last sample strobe
   logic [9:0] gap_q;
   logic       seen_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= smp_vld ? 10'h000 : gap_q + 10'h001;
         if (smp_vld) seen_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_tick;
      tick |=> !tick [*3] ##1 tick;
   endproperty
   a_tick: assert property (p_tick) // [R1]
      else $error("modulator strobe not every fourth clock");

   property p_rate;
      smp_vld && seen_q |-> gap_q == 10'(SMP_PERIOD - 1);
   endproperty
   a_rate: assert property (p_rate) // [R3]
      else $error("sample period is not 512 clocks");

   property p_alias;
      wr && ad == ADDR_GIB + GAIN_ALIAS |=> gib_q == $past(wd);
   endproperty
   a_alias: assert property (p_alias) // [R7]
      else $error("upper-page gain write lost");

   property p_cfg_rst;
      $rose(rst_n) |-> cfg_q == CFG_RST && !reference_external;
   endproperty
   a_cfg_rst: assert property (@(posedge clock) p_cfg_rst) // [R8]
      else $error("control registers not at reset value");

   property p_ref;
      wr && hit_ref |=> reference_external == $past(wd[REF_EXT]);
   endproperty
   a_ref: assert property (p_ref) // [R15]
      else $error("reference select did not follow write");

   property p_amp;
      wr && hit_ama && !ok_ama |=> $stable(current_amp_setting_a);
   endproperty
   a_amp: assert property (p_amp) // [R16]
      else $error("illegal amplifier code accepted");

   property p_align;
      post_vld == '0 || post_vld == '1;
   endproperty
   a_align: assert property (p_align) // [R17]
      else $error("channel samples not aligned");

   property p_order;
      dec_tick |-> ##2 smp_vld ##1 !smp_vld [*8];
   endproperty
   a_order: assert property (p_order) // [R18]
      else $error("conditioned sample not two cycles after decimation");

   c_sample: cover property (smp_vld && seen_q);
   c_hpf_off: cover property (smp_vld && !cfg_q[CFG_HPF]);
   c_int_b: cover property (smp_vld && cfg_q[CFG_INT_B]);

endmodule // mas_signal_path

// ===== mas_mod_model.sv
// Purpose: stand-in for the three modulators feeding the signal path
// Assumes: the bench picks a constant density per channel
// Notes: bits move only after a sampling pulse, like a real modulator
`timescale 1ns/10ps
module mas_mod_model (
   // clock and modulator timing
   input  wire logic       clock,
   input  wire logic       mod_strobe,
   // density per channel: 1 all ones, 0 all zeros
   input  wire logic [2:0] level,
   // modulator streams
   output logic      [2:0] bits
);
   initial bits = 3'h0;
   always @(posedge clock) begin
      if (mod_strobe) begin
         bits <= level;
      end
   end
endmodule // mas_mod_model

// ===== mas_signal_path_bench.sv
// Purpose: self-checking bench for the metering signal path
// Assumes: gain law out = x + (x*g)>>>23, raw full scale +/-6,496,256
// Notes: dc block is bypassed for exact sample values
`timescale 1ns/10ps
module mas_signal_path_bench;
   import mas_pkg::*;
   localparam logic [23:0] FS_P = 24'h63_2000;
   localparam logic [23:0] FS_N = 24'h9c_e000;
   localparam logic [23:0] HF_P = 24'h31_9000;
   localparam logic [23:0] G_HALF = 24'hc0_0000;
   logic           clock;
   logic           rst_n;
   logic [2:0]     level;
   logic [NCH-1:0] mod_bit_pin;
   logic           mod_strobe;
   mas_req_s       reg_req;
   logic [23:0]    reg_rdata;
   logic           reg_rvld;
   logic [2:0]     amp_a;
   logic [2:0]     amp_b;
   logic [2:0]     amp_v;
   logic           ref_ext;
   logic           smp_vld;
   mas_smp_s       smp;
   int             n_mismatch;
   int             num_checks;

   mas_signal_path dut (.clock(clock), .rst_n(rst_n),
      .mod_bit_pin(mod_bit_pin), .mod_strobe(mod_strobe),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvld(reg_rvld),
      .current_amp_setting_a(amp_a), .current_amp_setting_b(amp_b),
      .voltage_amp_setting(amp_v), .reference_external(ref_ext),
      .smp_vld(smp_vld), .smp(smp));
   mas_mod_model modl (.clock(clock), .mod_strobe(mod_strobe),
      .level(level), .bits(mod_bit_pin));

   always #4 clock = ~clock;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // a changed sample must differ from the raw value and be fully known
   task automatic chk_ne(input logic [23:0] got, input logic [23:0] old);
      num_checks++;
      if (got === old || $isunknown(got)) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h not=%h", $time, got, old);
      end
   endtask

   // one write, released on the next edge; step off it so callers
   // see the registered result, not the value before the edge
   task automatic reg_wr(input logic [11:0] a, input logic [23:0] d);
      @(posedge clock);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      reg_req <= '0;
      #1;
   endtask

   // read data answers one cycle after the request is taken
   task automatic reg_rd(input logic [11:0] a, input logic [23:0] exp);
      @(posedge clock);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h00_0000};
      @(posedge clock);
      reg_req <= '0;
      #1;
      chk1(reg_rvld, 1'b1);
      chk24(reg_rdata, exp);
   endtask

   task automatic wait_smp(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         for (k = 0; k < 600; k++) begin
            @(posedge clock);
            #1;
            if (smp_vld === 1'b1) break;
         end
         if (k == 600) begin
            n_mismatch++;
            print_verdict();
         end
      end
   endtask

   task automatic t_reset();
      reg_rd(ADDR_CFG, 24'h00_0004);
      reg_rd(ADDR_GIA, 24'h00_0000);
      reg_rd(ADDR_REF, 24'h00_0000);
      reg_rd(ADDR_AMPA, 24'h00_0000);
      reg_rd(ADDR_AMPB, 24'h00_0000);
      reg_rd(ADDR_AMPV, 24'h00_0000);
      chk1(ref_ext, 1'b0);
      chk24({18'h0, amp_a, amp_v}, 24'h00_0000);
   endtask

   task automatic t_strobe();
      int cnt;
      cnt = 0;
      for (int i = 0; i < 400; i++) begin
         @(posedge clock);
         #1;
         if (mod_strobe === 1'b1) cnt++;
      end
      chk24(24'(cnt), 24'h00_0064);
   endtask

   task automatic t_alias();
      logic [11:0] b [4] = '{ADDR_GIA, ADDR_GVP, ADDR_GIB, ADDR_GVS};
      for (int i = 0; i < 4; i++) begin
         reg_wr(b[i] + GAIN_ALIAS, 24'h5a_0000 + 24'(i));
         reg_rd(b[i], 24'h5a_0000 + 24'(i));
         reg_wr(b[i], 24'h00_0000);
         reg_rd(b[i] + GAIN_ALIAS, 24'h00_0000);
      end
   endtask

   task automatic t_amp_ref();
      reg_wr(ADDR_AMPA, 24'h00_0005);
      reg_wr(ADDR_AMPB, 24'h00_0005);
      reg_wr(ADDR_AMPV, 24'h00_0004);
      reg_rd(ADDR_AMPB, 24'h00_0000);
      chk24({18'h0, amp_a, amp_v}, 24'h00_002c);
      reg_wr(ADDR_AMPA, 24'h00_0006);
      chk24({21'h0, amp_a}, 24'h00_0005);
      reg_wr(ADDR_AMPB, 24'h00_0004);
      reg_rd(ADDR_AMPB, 24'h00_0004);
      chk24({21'h0, amp_b}, 24'h00_0004);
      reg_wr(ADDR_REF, 24'h00_0001);
      chk1(ref_ext, 1'b1);
      reg_wr(ADDR_REF, 24'h00_0000);
      chk1(ref_ext, 1'b0);
   endtask

   task automatic t_period();
      int cnt;
      wait_smp(1);
      for (cnt = 1; cnt < 600; cnt++) begin
         @(posedge clock);
         #1;
         if (smp_vld === 1'b1) break;
      end
      chk24(24'(cnt), 24'h00_0200);
   endtask

   task automatic t_raw();
      reg_wr(ADDR_CFG, 24'h00_0000);
      wait_smp(5);
      chk24(smp.ia, FS_P);
      chk24(smp.ib, FS_P);
      chk24(smp.v, FS_P);
      level <= 3'b000;
      wait_smp(5);
      chk24(smp.ia, FS_N);
      chk24(smp.v, FS_N);
      level <= 3'b111;
      wait_smp(5);
   endtask

   task automatic t_gain();
      reg_wr(ADDR_GIA + GAIN_ALIAS, G_HALF);
      wait_smp(2);
      chk24(smp.ia, HF_P);
      chk24(smp.ib, FS_P);
      reg_wr(ADDR_GIA, 24'h00_0000);
      reg_wr(ADDR_GIB, G_HALF);
      reg_wr(ADDR_GVP, G_HALF);
      reg_wr(ADDR_GVS, G_HALF);
      wait_smp(2);
      chk24(smp.ia, FS_P);
      chk24(smp.ib, HF_P);
      chk24(smp.v, HF_P);
      reg_wr(ADDR_GIB, 24'h00_0000);
      reg_wr(ADDR_GVP, 24'h00_0000);
      reg_wr(ADDR_GVS, 24'h00_0000);
   endtask

   // integrators only as if di/dt sensors were fitted
   task automatic t_integ();
      reg_wr(ADDR_CFG, 24'h00_0001);
      wait_smp(3);
      chk_ne(smp.ia, FS_P);
      chk24(smp.ib, FS_P);
      reg_wr(ADDR_CFG, 24'h00_0002);
      wait_smp(3);
      chk24(smp.ia, FS_P);
      chk_ne(smp.ib, FS_P);
      chk24(smp.v, FS_P);
   endtask

   task automatic t_dc_block();
      reg_wr(ADDR_CFG, 24'h00_0004);
      wait_smp(6);
      chk_ne(smp.ia, FS_P);
      chk_ne(smp.v, FS_P);
      reg_wr(ADDR_CFG, 24'h00_0000);
      wait_smp(3);
      chk24(smp.v, FS_P);
   endtask

   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      level = 3'b111;
      reg_req = '0;
      n_mismatch = 0;
      num_checks = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_strobe();
      t_alias();
      t_amp_ref();
      t_period();
      t_raw();
      t_gain();
      t_integ();
      t_dc_block();
      print_verdict();
   end
endmodule // mas_signal_path_bench
